// ### pkg/pll_ctl_pkg.sv
// Summary of operation
// - n, m and every post-scale counter carry a delay, 250 ps steps over 3.0 ns.
// - m delay moves outputs earlier, n later, post delay only its own output.
// - Normal mode: output delay is n minus m plus own post delay.
// - External feedback: the fed-back external counter delay subtracts instead.
// - Delays change at run time; phase tap selection is not reachable.
// - Spread spectrum gives 0.5% triangular down spread, programmable rate, as an offset on SS_OFFSET_OUT and status only; clock outputs unaffected.
// - Lock flag marks a stable in-phase output; fabric should filter it.
// - Each post-scale counter has separate high and low counts for duty cycle.
// - Global enable low grounds all outputs and drops lock.
// - Global enable high again relocks and resynchronises to the reference.
// - Clear high resets counters, grounds outputs, drops lock, VCO to nominal 700 MHz.
// - Clear release relocks; below-nominal targets run fast until lock.
// - Phase detector disabled: VCO holds and keeps running without reference.
// - Each global and external output has its own output enable.
// - Output enables are sampled at the falling edge of their counter clock.
// - Output enables never touch loop counters; lock drops only on disable or re-enable of the fed-back counter in external feedback.
// - External enables gate e0 to e3 alike; relock only in external feedback.
// - In external feedback one external counter closes the loop via the feedback pin.
package pll_ctl_pkg;

  localparam int ADDR_W   = 6;
  localparam int DATA_W   = 32;
  localparam int NUM_OUT  = 12;
  localparam int NUM_GL   = 8;
  localparam int NUM_EXT  = 4;
  localparam int CNT_W    = 8;
  localparam int DLY_W    = 4;
  localparam int TOT_W    = 7;
  localparam int WD_W     = 16;

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] data_t;

  // Register word addresses.
  localparam addr_t REG_CTRL       = 6'h00;
  localparam addr_t REG_CLK_ENA    = 6'h01;
  localparam addr_t REG_NM_DELAY   = 6'h02;
  localparam addr_t REG_POST_DLY   = 6'h03;
  localparam addr_t REG_SS_RATE    = 6'h06;
  localparam addr_t REG_STATUS     = 6'h07;
  localparam addr_t REG_DUTY_BASE  = 6'h08;
  localparam addr_t REG_TOTAL_BASE = 6'h14;

  // Input pin indices inside the synchroniser vectors.
  localparam int PIN_PLLEN = 0;
  localparam int PIN_REF   = 1;
  localparam int PIN_FB    = 2;
  localparam int NUM_PINS  = 3;

  typedef struct packed {
    logic       below_nom;
    logic [1:0] fb_sel;
    logic       ext_fb;
    logic       ss_en;
    logic       pfd_en;
    logic       areset;
  } ctrl_t;
  localparam int CTRL_W = $bits(ctrl_t);

  typedef struct packed {
    logic [CNT_W-1:0] low;
    logic [CNT_W-1:0] high;
  } duty_t;
  localparam int DUTY_W = $bits(duty_t);

  typedef struct packed {
    logic [CNT_W-1:0] ss_off;
    logic [2:0]       zero;
    logic             skew_err;
    logic             range_err;
    logic             vco_nom;
    logic             pll_en;
    logic             locked;
  } status_t;

  typedef enum logic [1:0] {ST_RESET, ST_ACQUIRE, ST_LOCKED, ST_HOLD} lock_state_t;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             phase;
    logic             ena;
    logic             clk;
  } pscale_state_t;

  // Reset values.
  localparam ctrl_t              CTRL_RST    = 7'h02;
  localparam logic [NUM_OUT-1:0] CLK_ENA_RST = 12'hFFF;
  localparam duty_t              DUTY_RST    = 16'h0101;
  localparam logic [15:0]        SS_RATE_RST = 16'h0010;

  // Timing at 20 MHz core clock.
  localparam int CLK_PERIOD_PS  = 50000;
  localparam int REF_TIMEOUT_NS = 2000;
  localparam logic [WD_W-1:0] REF_TIMEOUT_CYC =
    WD_W'(REF_TIMEOUT_NS * 1000 / CLK_PERIOD_PS);
  localparam logic [4:0] LOCK_EDGES = 5'h10;

  // Delay arithmetic in 250 ps steps.
  localparam int DELAY_STEP_PS = 250;
  localparam int DELAY_SPAN_PS = 3000;
  localparam int TOTAL_MIN_PS  = -3000;
  localparam int TOTAL_MAX_PS  = 6000;
  localparam int SKEW_MAX_PS   = 3000;
  localparam logic [DLY_W-1:0] DELAY_MAX_STEPS = DLY_W'(DELAY_SPAN_PS / DELAY_STEP_PS);
  localparam logic signed [TOT_W-1:0] TOTAL_MIN_STEPS = TOT_W'(TOTAL_MIN_PS / DELAY_STEP_PS);
  localparam logic signed [TOT_W-1:0] TOTAL_MAX_STEPS = TOT_W'(TOTAL_MAX_PS / DELAY_STEP_PS);
  localparam logic signed [TOT_W-1:0] SKEW_MAX_STEPS  = TOT_W'(SKEW_MAX_PS / DELAY_STEP_PS);

  // Spread depth in hundredths of a percent; 50 is 0.5 percent.
  localparam logic [CNT_W-1:0] SS_STEPS = 8'h32;
  localparam int VCO_NOMINAL_MHZ = 700;

endpackage : pll_ctl_pkg

// ### logic/pscale_counter.sv
module pscale_counter (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  // Control
  input  wire logic                 clear_in,
  input  wire logic                 fast_in,
  input  wire logic                 ena_in,
  input  wire pll_ctl_pkg::duty_t   duty_in,
  // Gated output clock
  output logic                      clk_out
);
  import pll_ctl_pkg::*;

  pscale_state_t st_reg;
  pscale_state_t st_next;
  logic [CNT_W-1:0] limit;

  // Zero counts act as one; while running fast the counts halve.
  function automatic logic [CNT_W-1:0] eff_count(input logic [CNT_W-1:0] c, input logic f);
    logic [CNT_W-1:0] v;
    v = f ? (c >> 1) : c;
    return (v == '0) ? CNT_W'(1) : v;
  endfunction : eff_count

  always_comb begin
    st_next = st_reg;
    limit   = st_reg.phase ? eff_count(duty_in.high, fast_in) : eff_count(duty_in.low, fast_in);
    if (clear_in) begin
      st_next.cnt   = '0;
      st_next.phase = 1'b1;
      st_next.ena   = ena_in;
      st_next.clk   = 1'b0;
    end else begin
      if (st_reg.cnt >= limit - CNT_W'(1)) begin
        st_next.cnt   = '0;
        st_next.phase = ~st_reg.phase;
        if (st_reg.phase) begin
          st_next.ena = ena_in;
        end
      end else begin
        st_next.cnt = st_reg.cnt + CNT_W'(1);
      end
      st_next.clk = st_next.phase & st_next.ena;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign clk_out = st_reg.clk;

endmodule : pscale_counter

// ### logic/pll_ctl_top.sv
// Local design decisions: the register offsets and the plain strobed port.
module pll_ctl_top (
  // Clock and reset
  input  wire logic                         CORE_CLK_IN,
  input  wire logic                         ARST_N_IN,
  // Register port
  input  wire pll_ctl_pkg::addr_t           ADDR_IN,
  input  wire pll_ctl_pkg::data_t           WR_DATA_IN,
  input  wire logic                         WR_EN_IN,
  input  wire logic                         RD_EN_IN,
  output pll_ctl_pkg::data_t                RD_DATA_OUT,
  // Pins from outside the clock domain
  input  wire logic                         PLL_ENABLE_IN,
  input  wire logic                         REF_CLK_IN,
  input  wire logic                         FEEDBACK_INPUT_PIN_IN,
  // Output clocks
  output logic [pll_ctl_pkg::NUM_GL-1:0]    CLK_OUT,
  output logic [pll_ctl_pkg::NUM_EXT-1:0]   EXT_CLK_OUT,
  // Status
  output logic                              LOCKED_OUT,
  output logic                              VCO_NOMINAL_OUT,
  output logic [pll_ctl_pkg::CNT_W-1:0]     SS_OFFSET_OUT
);
  import pll_ctl_pkg::*;

  typedef struct packed {
    ctrl_t                          ctrl;
    logic [NUM_OUT-1:0]             clk_ena;
    logic [DLY_W-1:0]               n_dly;
    logic [DLY_W-1:0]               m_dly;
    logic [NUM_OUT-1:0][DLY_W-1:0]  post_dly;
    logic [15:0]                    ss_rate;
    duty_t [NUM_OUT-1:0]            duty;
    data_t                          rd_data;
    logic [NUM_PINS-1:0]            sync1;
    logic [NUM_PINS-1:0]            sync2;
    logic [NUM_PINS-1:0]            prev;
    lock_state_t                    lst;
    logic [4:0]                     acq_cnt;
    logic [WD_W-1:0]                ref_wd;
    logic [WD_W-1:0]                fb_wd;
    logic                           locked;
    logic                           vco_nom;
    logic [15:0]                    ss_div;
    logic [CNT_W-1:0]               ss_off;
    logic                           ss_down;
    logic [NUM_EXT-1:0]             ext_ena_prev;
  } top_state_t;

  top_state_t st_reg;
  top_state_t st_next;

  logic signed [TOT_W-1:0] total [NUM_OUT];
  logic signed [TOT_W-1:0] tot_min;
  logic signed [TOT_W-1:0] tot_max;
  logic                    range_err;
  logic                    skew_err;
  logic                    clear;
  logic                    fast;
  logic                    ref_edge;
  logic                    fb_edge;
  logic                    ref_lost;
  logic                    fb_lost;
  logic                    relock;
  logic [NUM_OUT-1:0]      cnt_clk;
  status_t                 status;
  int                      fb_idx;

  // Settings beyond the element span saturate at the span.
  function automatic logic [DLY_W-1:0] clamp_dly(input logic [DLY_W-1:0] v);
    return (v > DELAY_MAX_STEPS) ? DELAY_MAX_STEPS : v;
  endfunction : clamp_dly

  // Combined delay of one output in steps.
  function automatic logic signed [TOT_W-1:0] total_delay(
    input logic [DLY_W-1:0] n,
    input logic [DLY_W-1:0] m,
    input logic [DLY_W-1:0] post,
    input logic             in_loop
  );
    logic signed [TOT_W-1:0] sn;
    logic signed [TOT_W-1:0] sm;
    logic signed [TOT_W-1:0] sp;
    sn = signed'(TOT_W'(n));
    sm = signed'(TOT_W'(m));
    sp = signed'(TOT_W'(post));
    return in_loop ? (sn - sm - sp) : (sn - sm + sp);
  endfunction : total_delay

  assign fb_idx = NUM_GL + int'(st_reg.ctrl.fb_sel);

  always_comb begin
    tot_min = TOTAL_MAX_STEPS;
    tot_max = TOTAL_MIN_STEPS;
    range_err = 1'b0;
    for (int i = 0; i < NUM_OUT; i++) begin
      total[i] = total_delay(st_reg.n_dly, st_reg.m_dly, st_reg.post_dly[i],
                             st_reg.ctrl.ext_fb && (i == fb_idx));
      if (total[i] < tot_min) begin
        tot_min = total[i];
      end
      if (total[i] > tot_max) begin
        tot_max = total[i];
      end
      if (total[i] < TOTAL_MIN_STEPS || total[i] > TOTAL_MAX_STEPS) begin
        range_err = 1'b1;
      end
    end
    skew_err = (tot_max - tot_min) >= SKEW_MAX_STEPS;
  end

  // Only the second synchroniser stage and its delayed copy feed logic.
  assign ref_edge = st_reg.sync2[PIN_REF] & ~st_reg.prev[PIN_REF];
  assign fb_edge  = st_reg.sync2[PIN_FB] & ~st_reg.prev[PIN_FB];
  assign ref_lost = st_reg.ref_wd >= REF_TIMEOUT_CYC;
  assign fb_lost  = st_reg.ctrl.ext_fb && (st_reg.fb_wd >= REF_TIMEOUT_CYC);

  assign clear = st_reg.ctrl.areset | ~st_reg.sync2[PIN_PLLEN];

  assign fast = st_reg.ctrl.below_nom && (st_reg.lst == ST_ACQUIRE);

  assign relock = st_reg.ctrl.ext_fb &&
                  st_reg.clk_ena[fb_idx] && !st_reg.ext_ena_prev[st_reg.ctrl.fb_sel];

  always_comb begin
    status           = '0;
    status.locked    = st_reg.locked;
    status.pll_en    = st_reg.sync2[PIN_PLLEN];
    status.vco_nom   = st_reg.vco_nom;
    status.range_err = range_err;
    status.skew_err  = skew_err;
    status.ss_off    = st_reg.ss_off;
  end

  always_comb begin
    st_next = st_reg;

    st_next.sync1        = {FEEDBACK_INPUT_PIN_IN, REF_CLK_IN, PLL_ENABLE_IN};
    st_next.sync2        = st_reg.sync1;
    st_next.prev         = st_reg.sync2;
    st_next.ext_ena_prev = st_reg.clk_ena[NUM_OUT-1:NUM_GL];

    // Register writes.
    if (WR_EN_IN) begin
      unique case (ADDR_IN)
        REG_CTRL: begin
          st_next.ctrl = ctrl_t'(WR_DATA_IN[CTRL_W-1:0]);
        end
        REG_CLK_ENA: begin
          st_next.clk_ena = WR_DATA_IN[NUM_OUT-1:0];
        end
        REG_NM_DELAY: begin
          st_next.n_dly = clamp_dly(WR_DATA_IN[DLY_W-1:0]);
          st_next.m_dly = clamp_dly(WR_DATA_IN[2*DLY_W-1:DLY_W]);
        end
        REG_SS_RATE: begin
          st_next.ss_rate = WR_DATA_IN[15:0];
        end
        default: begin
          for (int g = 0; g < NUM_OUT / NUM_EXT; g++) begin
            if (ADDR_IN == addr_t'(REG_POST_DLY + g)) begin
              for (int k = 0; k < NUM_EXT; k++) begin
                st_next.post_dly[g*NUM_EXT+k] = clamp_dly(WR_DATA_IN[k*DLY_W +: DLY_W]);
              end
            end
          end
          for (int i = 0; i < NUM_OUT; i++) begin
            if (ADDR_IN == addr_t'(REG_DUTY_BASE + i)) begin
              st_next.duty[i] = duty_t'(WR_DATA_IN[DUTY_W-1:0]);
            end
          end
        end
      endcase
    end

    // Read data stands for exactly one cycle.
    st_next.rd_data = '0;
    if (RD_EN_IN) begin
      unique case (ADDR_IN)
        REG_CTRL: begin
          st_next.rd_data = data_t'(st_reg.ctrl);
        end
        REG_CLK_ENA: begin
          st_next.rd_data = data_t'(st_reg.clk_ena);
        end
        REG_NM_DELAY: begin
          st_next.rd_data = data_t'({st_reg.m_dly, st_reg.n_dly});
        end
        REG_SS_RATE: begin
          st_next.rd_data = data_t'(st_reg.ss_rate);
        end
        REG_STATUS: begin
          st_next.rd_data = data_t'(status);
        end
        default: begin
          for (int g = 0; g < NUM_OUT / NUM_EXT; g++) begin
            if (ADDR_IN == addr_t'(REG_POST_DLY + g)) begin
              st_next.rd_data = data_t'(st_reg.post_dly[g*NUM_EXT +: NUM_EXT]);
            end
          end
          for (int i = 0; i < NUM_OUT; i++) begin
            if (ADDR_IN == addr_t'(REG_DUTY_BASE + i)) begin
              st_next.rd_data = data_t'(st_reg.duty[i]);
            end
            if (ADDR_IN == addr_t'(REG_TOTAL_BASE + i)) begin
              st_next.rd_data = data_t'(signed'(total[i]));
            end
          end
        end
      endcase
    end

    // Reference and feedback watchdogs saturate at the timeout.
    if (ref_edge) begin
      st_next.ref_wd = '0;
    end else if (!ref_lost) begin
      st_next.ref_wd = st_reg.ref_wd + WD_W'(1);
    end
    if (fb_edge || !st_reg.ctrl.ext_fb) begin
      st_next.fb_wd = '0;
    end else if (!fb_lost) begin
      st_next.fb_wd = st_reg.fb_wd + WD_W'(1);
    end

    // Loop state.
    if (clear) begin
      st_next.lst     = ST_RESET;
      st_next.locked  = 1'b0;
      st_next.acq_cnt = '0;
      st_next.vco_nom = 1'b1;
    end else begin
      unique case (st_reg.lst)
        ST_RESET: begin
          st_next.lst     = ST_ACQUIRE;
          st_next.acq_cnt = '0;
        end
        ST_ACQUIRE: begin
          st_next.locked = 1'b0;
          if (!st_reg.ctrl.pfd_en) begin
            st_next.lst = ST_HOLD;
          end else if (ref_lost || fb_lost) begin
            st_next.acq_cnt = '0;
          end else if (ref_edge) begin
            st_next.vco_nom = 1'b0;
            if (st_reg.acq_cnt == LOCK_EDGES - 5'h01) begin
              st_next.lst    = ST_LOCKED;
              st_next.locked = 1'b1;
            end else begin
              st_next.acq_cnt = st_reg.acq_cnt + 5'h01;
            end
          end
        end
        ST_LOCKED: begin
          if (!st_reg.ctrl.pfd_en) begin
            st_next.lst = ST_HOLD;
          end else if (ref_lost || fb_lost || relock) begin
            st_next.lst     = ST_ACQUIRE;
            st_next.locked  = 1'b0;
            st_next.acq_cnt = '0;
          end
        end
        ST_HOLD: begin
          if (ref_lost) begin
            st_next.locked = 1'b0;
          end
          if (st_reg.ctrl.pfd_en) begin
            st_next.lst     = ST_ACQUIRE;
            st_next.locked  = 1'b0;
            st_next.acq_cnt = '0;
          end
        end
      endcase
    end

    if (clear || !st_reg.ctrl.ss_en) begin
      st_next.ss_div  = '0;
      st_next.ss_off  = '0;
      st_next.ss_down = 1'b0;
    end else if (st_reg.ss_div >= st_reg.ss_rate) begin
      st_next.ss_div = '0;
      if (!st_reg.ss_down) begin
        if (st_reg.ss_off == SS_STEPS) begin
          st_next.ss_down = 1'b1;
          st_next.ss_off  = st_reg.ss_off - CNT_W'(1);
        end else begin
          st_next.ss_off = st_reg.ss_off + CNT_W'(1);
        end
      end else begin
        if (st_reg.ss_off == '0) begin
          st_next.ss_down = 1'b0;
          st_next.ss_off  = CNT_W'(1);
        end else begin
          st_next.ss_off = st_reg.ss_off - CNT_W'(1);
        end
      end
    end else begin
      st_next.ss_div = st_reg.ss_div + 16'h0001;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      st_reg          <= '0;
      st_reg.ctrl     <= CTRL_RST;
      st_reg.clk_ena  <= CLK_ENA_RST;
      st_reg.ss_rate  <= SS_RATE_RST;
      st_reg.duty     <= {NUM_OUT{DUTY_RST}};
      st_reg.lst      <= ST_RESET;
      st_reg.vco_nom  <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  for (genvar i = 0; i < NUM_OUT; i++) begin : g_cnt
    pscale_counter u_cnt (
      .clk_in   (CORE_CLK_IN),
      .rst_n_in (ARST_N_IN),
      .clear_in (clear),
      .fast_in  (fast),
      .ena_in   (st_reg.clk_ena[i]),
      .duty_in  (st_reg.duty[i]),
      .clk_out  (cnt_clk[i])
    );
  end

  assign CLK_OUT         = cnt_clk[NUM_GL-1:0];
  assign EXT_CLK_OUT     = cnt_clk[NUM_OUT-1:NUM_GL];
  assign LOCKED_OUT      = st_reg.locked;
  assign VCO_NOMINAL_OUT = st_reg.vco_nom;
  assign SS_OFFSET_OUT   = st_reg.ss_off;
  assign RD_DATA_OUT     = st_reg.rd_data;

endmodule : pll_ctl_top

// ### tb/pll_ctl_monitor.sv
module pll_ctl_monitor (
  // Clock and reset
  input wire logic                          CORE_CLK_IN,
  input wire logic                          ARST_N_IN,
  // Watched inputs
  input wire pll_ctl_pkg::addr_t            ADDR_IN,
  input wire pll_ctl_pkg::data_t            WR_DATA_IN,
  input wire logic                          WR_EN_IN,
  input wire logic                          PLL_ENABLE_IN,
  // Watched outputs
  input wire logic [pll_ctl_pkg::NUM_GL-1:0]  CLK_OUT,
  input wire logic [pll_ctl_pkg::NUM_EXT-1:0] EXT_CLK_OUT,
  input wire logic                          LOCKED_OUT,
  input wire logic                          VCO_NOMINAL_OUT,
  input wire logic [pll_ctl_pkg::CNT_W-1:0]   SS_OFFSET_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  import pll_ctl_pkg::*;
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (!ARST_N_IN);

  // Six cycles cover the two-flop pin synchroniser plus the registered flag.
  a_off_no_lock: assert property (!PLL_ENABLE_IN [*6] |-> !LOCKED_OUT)
    else $error("lock flag high with enable pin low");
  a_off_gnd_out: assert property (!PLL_ENABLE_IN [*6] |-> CLK_OUT == '0 && EXT_CLK_OUT == '0)
    else $error("output clock running with enable pin low");
  a_clr_drops_lock: assert property (WR_EN_IN && ADDR_IN == REG_CTRL && WR_DATA_IN[0]
    |-> ##2 (!LOCKED_OUT && CLK_OUT == '0 && EXT_CLK_OUT == '0 && VCO_NOMINAL_OUT))
    else $error("clear did not stop outputs and lock");
  a_ss_in_range: assert property (SS_OFFSET_OUT <= SS_STEPS)
    else $error("spread offset beyond depth");
  a_ss_unit_step: assert property ($changed(SS_OFFSET_OUT) |->
    SS_OFFSET_OUT == $past(SS_OFFSET_OUT) + 8'h01 ||
    SS_OFFSET_OUT + 8'h01 == $past(SS_OFFSET_OUT) || SS_OFFSET_OUT == 8'h00)
    else $error("spread offset is not a triangle");
  a_nom_not_locked: assert property (VCO_NOMINAL_OUT |-> !LOCKED_OUT)
    else $error("locked while at nominal frequency");
  a_lock_after_acq: assert property ($rose(LOCKED_OUT) |-> !$past(VCO_NOMINAL_OUT))
    else $error("lock without acquisition");
  a_lock_needs_en: assert property ($rose(LOCKED_OUT) |-> $past(PLL_ENABLE_IN, 4))
    else $error("lock rose without enable pin");

  c_locked: cover property ($rose(LOCKED_OUT));
  c_ss_peak: cover property (SS_OFFSET_OUT == SS_STEPS);
  c_pin_off: cover property (!PLL_ENABLE_IN [*6]);
endmodule : pll_ctl_monitor

bind pll_ctl_top pll_ctl_monitor mon (
  .CORE_CLK_IN,
  .ARST_N_IN,
  .ADDR_IN,
  .WR_DATA_IN,
  .WR_EN_IN,
  .PLL_ENABLE_IN,
  .CLK_OUT,
  .EXT_CLK_OUT,
  .LOCKED_OUT,
  .VCO_NOMINAL_OUT,
  .SS_OFFSET_OUT
);

// ### tb/fabric_model.sv
module fabric_model (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Reference control and raw lock
  input  wire logic run_in,
  input  wire logic locked_in,
  // Reference and filtered lock
  output logic      ref_out,
  output logic      lock_ok_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] stable_reg;

  // A stopped reference rests low; the period is unrelated to the core clock.
  initial begin
    ref_out = 1'b0;
    forever begin
      #170;
      ref_out = run_in ? ~ref_out : 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stable_reg <= 4'h0;
    end else if (!locked_in) begin
      stable_reg <= 4'h0;
    end else if (stable_reg != 4'hF) begin
      stable_reg <= stable_reg + 4'h1;
    end
  end
  assign lock_ok_out = (stable_reg == 4'hF);
endmodule : fabric_model

// ### tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pll_ctl_pkg::*;
  logic        clk, rst_n, wr_en, rd_en, pll_en, ref_run, ref_clk, lock_ok;
  logic        locked, vco_nom;
  addr_t       addr;
  data_t       wdata, rdata, d;
  logic [7:0]  clk_out, ss_off;
  logic [3:0]  ext_out;
  logic [11:0] seen;
  int          err_count, n_compared, cycles, len;
  data_t       tot [4] = '{32'h0000_0000, 32'h0000_0008, 32'h0000_000A, 32'hFFFF_FFFE};

  pll_ctl_top dut (.CORE_CLK_IN(clk), .ARST_N_IN(rst_n), .ADDR_IN(addr),
    .WR_DATA_IN(wdata), .WR_EN_IN(wr_en), .RD_EN_IN(rd_en), .RD_DATA_OUT(rdata),
    .PLL_ENABLE_IN(pll_en), .REF_CLK_IN(ref_clk), .FEEDBACK_INPUT_PIN_IN(ext_out[1]),
    .CLK_OUT(clk_out), .EXT_CLK_OUT(ext_out), .LOCKED_OUT(locked),
    .VCO_NOMINAL_OUT(vco_nom), .SS_OFFSET_OUT(ss_off));
  fabric_model fab (.clk_in(clk), .rst_n_in(rst_n), .run_in(ref_run), .locked_in(locked),
    .ref_out(ref_clk), .lock_ok_out(lock_ok));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t: saw %h, want %h", $time, s, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input addr_t a, input data_t v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input addr_t a, output data_t v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask : rd
  task automatic rchk(input addr_t a, input data_t e);
    data_t v;
    rd(a, v);
    chk(v, e);
  endtask : rchk
  task automatic act(input int n);
    seen = '0;
    repeat (n) begin
      tick(1);
      seen = seen | {ext_out, clk_out};
    end
  endtask : act
  // Skips any high phase in progress so that a whole pulse is measured.
  task automatic hlen(input int e);
    for (int i = 0; i < 100 && clk_out[0] !== 1'b0; i++) tick(1);
    for (int i = 0; i < 100 && clk_out[0] !== 1'b1; i++) tick(1);
    for (len = 0; clk_out[0] === 1'b1 && len < 50; len++) tick(1);
    chk(32'(len), 32'(e));
  endtask : hlen
  task automatic wait_lock();
    for (int i = 0; i < 2000 && lock_ok !== 1'b1; i++) tick(1);
    chk(locked, 1'b1);
  endtask : wait_lock
  task automatic wait_ss(input logic [7:0] v);
    for (int i = 0; i < 300 && ss_off !== v; i++) tick(1);
    chk(ss_off, v);
  endtask : wait_ss
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    {rst_n, wr_en, rd_en, addr, wdata, cycles, err_count, n_compared} = '0;
    pll_en = 1'b1;
    ref_run = 1'b1;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rchk(REG_CTRL, 32'h0000_0002);
    rchk(REG_CLK_ENA, 32'h0000_0FFF);
    rchk(REG_SS_RATE, 32'h0000_0010);
    rchk(REG_DUTY_BASE, 32'h0000_0101);
    wr(6'h20, 32'hFFFF_FFFF);
    rchk(6'h20, 32'h0000_0000);
    // Post nibble 15 must saturate at the 3.0 ns span.
    wr(REG_NM_DELAY, 32'h0000_0053);
    wr(REG_POST_DLY, 32'h0000_0FA2);
    wr(addr_t'(REG_POST_DLY + 2), 32'h0000_0041);
    for (int i = 0; i < 4; i++) rchk(addr_t'(REG_TOTAL_BASE + i), tot[i]);
    rd(REG_STATUS, d);
    chk(d & 32'h0000_0018, 32'h0000_0010);
    wr(REG_CTRL, 32'h0000_001A);
    rchk(addr_t'(REG_TOTAL_BASE + 9), 32'hFFFF_FFFA);
    rchk(addr_t'(REG_TOTAL_BASE + 8), 32'hFFFF_FFFF);
    wr(REG_CTRL, 32'h0000_0002);
    rchk(addr_t'(REG_TOTAL_BASE + 9), 32'h0000_0002);
    wait_lock();
    chk(vco_nom, 1'b0);
    wr(REG_DUTY_BASE, 32'h0000_0203);
    wr(REG_CLK_ENA, 32'h0000_0EFE);
    tick(10);
    act(40);
    chk(32'(seen) & 32'h0000_0103, 32'h0000_0002);
    chk(locked, 1'b1);
    wr(REG_CLK_ENA, 32'h0000_0FFF);
    hlen(3);
    chk(locked, 1'b1);
    wr(REG_CTRL, 32'h0000_001A);
    wr(REG_CLK_ENA, 32'h0000_0DFF);
    wr(REG_CLK_ENA, 32'h0000_0FFF);
    tick(2);
    chk(locked, 1'b0);
    wait_lock();
    wr(REG_CLK_ENA, 32'h0000_0DFF);
    tick(50);
    chk(locked, 1'b0);
    wr(REG_CLK_ENA, 32'h0000_0FFF);
    wr(REG_CTRL, 32'h0000_0002);
    wr(REG_SS_RATE, 32'h0000_0000);
    wr(REG_CTRL, 32'h0000_0006);
    wait_ss(8'h32);
    wait_ss(8'h00);
    wr(REG_CTRL, 32'h0000_0002);
    wr(REG_SS_RATE, 32'h0000_0010);
    wr(REG_CTRL, 32'h0000_0000);
    ref_run <= 1'b0;
    tick(60);
    act(20);
    chk(32'(seen) & 32'h0000_0002, 32'h0000_0002);
    ref_run <= 1'b1;
    wr(REG_CTRL, 32'h0000_0002);
    wait_lock();
    wr(REG_CTRL, 32'h0000_0003);
    tick(4);
    chk({locked, vco_nom, ext_out, clk_out}, 32'h0000_1000);
    wr(REG_CTRL, 32'h0000_0042);
    hlen(1);
    wait_lock();
    hlen(3);
    @(posedge clk);
    pll_en <= 1'b0;
    tick(8);
    chk({locked, ext_out, clk_out}, 32'h0000_0000);
    rd(REG_STATUS, d);
    chk(d & 32'h0000_0003, 32'h0000_0000);
    @(posedge clk);
    pll_en <= 1'b1;
    wait_lock();
    conclude();
  end
endmodule : tb_top
